// ### hw/host_link_power_control.sv
// Restart, hibernate and wake sequencing with host attention and serial link.
//
// Contract
// (RL1) Host holds restart low during supply ramp.
// (RL2) Host releases restart about 1 ms later.
// (RL3) Ready 25 ms plus 1.35 s after restart.
// (RL4) Host holds pins steady 200 ms before power-off.
// (RL5) Host restarts by pulsing one pin low.
// (RL6) Restart low pulse lasts at least 200 ms.
// (RL7) Host stops processor before toggling restart.
// (RL8) Hibernate low pulse lasts at least 10 ms.
// (RL9) Ready 50 ms after hibernate exit.
// (RL10) Slow crystal stays on in hibernate.
// (RL11) Large temperature shift adds 200 ms recalibration.
// (RL12) Host keeps hibernate pulses above minimum always.
// (RL13) Attention line requests a host transfer.
// (RL14) Host link clock at most 20 MHz.
// (RL15) Link select is driven by host, active low.
// (RL16) Hibernate pin low holds module in hibernate.
// (RL17) Serial starts at 115200, host raises to 3M.
// (RL18) Eight bits, LSB first, no parity, one stop, CTS/RTS.
// (RL19) Host sees attention as active high.
// (RL20) Host waits for initialization before transactions.
`timescale 1ns/1ps
module host_link_power_control
  import link_power_pkg::*;
#(
  parameter int unsigned HW_WAKE_CYCLES  = HW_WAKE_CYC,
  parameter int unsigned INIT_CYCLES     = INIT_CYC,
  parameter int unsigned HIB_WAKE_CYCLES = HIB_WAKE_CYC,
  parameter int unsigned RECAL_CYCLES    = RECAL_EXTRA_CYC
)(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             module_restart_pin_n_i,
  input  wire logic             hibernate_request_pin_n_i,
  input  wire logic             temp_shift_i,
  input  wire logic             host_link_select_n_i,
  input  wire logic             cts_n_i,
  input  wire logic             rate_set_i,
  input  wire logic [DIV_W-1:0] rate_div_i,
  input  wire byte_beat_t       tx_i,
  output logic                  tx_ready_o,
  output logic                  txd_o,
  output logic                  rts_n_o,
  input  wire logic             rx_busy_i,
  input  wire logic             xfer_request_i,
  output logic                  host_attention_line_o,
  output logic                  ready_o,
  output logic                  hibernate_o,
  output logic                  slow_xtal_en_o,
  output logic [2:0]            pwr_state_o
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] rst_pin_sync_r;
  logic [1:0] hib_pin_sync_r;
  logic [1:0] sel_sync_r;
  logic [1:0] cts_sync_r;
  logic       restart_n;
  logic       hib_n;
  logic       sel_active;
  logic       cts_ok;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_pin_sync_r <= 2'h0;
      hib_pin_sync_r <= 2'h3;
      sel_sync_r     <= 2'h3;
      cts_sync_r     <= 2'h3;
    end else begin
      rst_pin_sync_r <= {rst_pin_sync_r[0], module_restart_pin_n_i};
      hib_pin_sync_r <= {hib_pin_sync_r[0], hibernate_request_pin_n_i};
      sel_sync_r     <= {sel_sync_r[0], host_link_select_n_i};
      cts_sync_r     <= {cts_sync_r[0], cts_n_i};
    end
  end

  assign restart_n  = rst_pin_sync_r[1];
  assign hib_n      = hib_pin_sync_r[1];
  assign sel_active = ~sel_sync_r[1]; // RL15
  assign cts_ok     = ~cts_sync_r[1]; // RL18

  // ---------------------------------------------------------------------------
  // Power sequencer
  // ---------------------------------------------------------------------------
  pwr_state_t  state_r;
  logic [31:0] wait_r;
  logic        recal_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= PWR_OFF;
      wait_r  <= '0;
    end else if (!restart_n) begin
      state_r <= PWR_OFF;
      wait_r  <= '0;
    end else begin
      case (state_r)
        PWR_OFF: begin
          state_r <= PWR_HW_WAKE; // RL3
          wait_r  <= 32'(HW_WAKE_CYCLES - 1);
        end
        PWR_HW_WAKE: begin
          if (wait_r == '0) begin
            state_r <= PWR_INIT;
            wait_r  <= 32'(INIT_CYCLES - 1); // RL3
          end else begin
            wait_r <= wait_r - 32'h1;
          end
        end
        PWR_INIT, PWR_HIB_WK: begin
          if (!hib_n) begin
            state_r <= PWR_HIB; // RL16
          end else if (wait_r == '0) begin
            state_r <= PWR_READY;
          end else begin
            wait_r <= wait_r - 32'h1;
          end
        end
        PWR_READY: begin
          if (!hib_n) begin
            state_r <= PWR_HIB; // RL16
          end
        end
        PWR_HIB: begin
          if (hib_n) begin
            state_r <= PWR_HIB_WK;
            wait_r  <= recal_r ? 32'(HIB_WAKE_CYCLES + RECAL_CYCLES - 1)
                               : 32'(HIB_WAKE_CYCLES - 1); // RL9 RL11
          end
        end
        default: begin
          state_r <= PWR_OFF;
          wait_r  <= '0;
        end
      endcase
    end
  end

  // A temperature shift seen during hibernate forces recalibration on wake.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      recal_r <= 1'b0;
    end else if (state_r == PWR_HIB) begin
      recal_r <= recal_r | temp_shift_i; // RL11
    end else if (state_r == PWR_HIB_WK) begin
      recal_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ready_o        <= 1'b0;
      hibernate_o    <= 1'b0;
      slow_xtal_en_o <= 1'b0;
      pwr_state_o    <= 3'h0;
    end else begin
      ready_o        <= (state_r == PWR_READY);
      hibernate_o    <= (state_r == PWR_HIB);
      slow_xtal_en_o <= (state_r != PWR_OFF); // RL10
      pwr_state_o    <= state_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Host attention and serial link
  // ---------------------------------------------------------------------------
  logic [DIV_W-1:0] div_r;
  logic             tx_ready;
  byte_beat_t       tx_gated;

  // Attention is held high in ready while data waits and the host has not selected.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_attention_line_o <= 1'b0;
    end else begin
      host_attention_line_o <= (state_r == PWR_READY) && xfer_request_i
                               && !sel_active; // RL13 RL19
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state_r == PWR_OFF) begin
      div_r <= BOOT_DIV; // RL17
    end else if (rate_set_i) begin
      div_r <= (rate_div_i < MIN_DIV) ? MIN_DIV : rate_div_i; // RL17
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1;
    end else begin
      rts_n_o <= !((state_r == PWR_READY) && !rx_busy_i); // RL18
    end
  end

  always_comb begin
    tx_gated       = tx_i;
    tx_gated.valid = tx_i.valid && (state_r == PWR_READY);
  end

  uart_char_tx u_tx (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .div_i      (div_r),
    .cts_ok_i   (cts_ok),
    .tx_i       (tx_gated),
    .tx_ready_o (tx_ready),
    .txd_o      (txd_o)
  );

  assign tx_ready_o = tx_ready && (state_r == PWR_READY);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_restart_off: assert property (@(posedge clk_sys_i) // RL3
    disable iff (rst_i) !restart_n |=> state_r == PWR_OFF)
    else $error("restart low did not stop module");
  a_hib_enter: assert property (@(posedge clk_sys_i) // RL16
    disable iff (rst_i)
    state_r == PWR_READY && !hib_n && restart_n |=> state_r == PWR_HIB)
    else $error("hibernate not entered");
  a_hib_hold: assert property (@(posedge clk_sys_i) // RL16
    disable iff (rst_i)
    state_r == PWR_HIB && !hib_n && restart_n |=> state_r == PWR_HIB)
    else $error("hibernate left while pin low");
  a_xtal_on: assert property (@(posedge clk_sys_i) // RL10
    disable iff (rst_i) state_r == PWR_HIB |=> slow_xtal_en_o)
    else $error("slow crystal off in hibernate");
  a_attn_ready: assert property (@(posedge clk_sys_i) // RL13
    disable iff (rst_i)
    host_attention_line_o |-> $past(state_r) == PWR_READY)
    else $error("attention outside ready");
  a_boot_rate: assert property (@(posedge clk_sys_i) // RL17
    disable iff (rst_i) state_r == PWR_OFF |=> div_r == BOOT_DIV)
    else $error("boot rate wrong");
  a_rate_cap: assert property (@(posedge clk_sys_i) // RL17
    disable iff (rst_i) div_r >= MIN_DIV)
    else $error("rate above maximum");
  a_start_bit: assert property (@(posedge clk_sys_i) // RL18
    disable iff (rst_i) tx_gated.valid && tx_ready |=> !txd_o)
    else $error("start bit missing");
  a_ready_wait: assert property (@(posedge clk_sys_i) // RL9
    disable iff (rst_i) $rose(state_r == PWR_HIB_WK) |-> !ready_o [*2])
    else $error("ready too early after wake");

endmodule

// ### hw/link_power_pkg.sv
// Package with constants and types for the host link power control block.
package link_power_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned HW_WAKE_MS      = 25;
  localparam int unsigned INIT_MS         = 1350;
  localparam int unsigned HIB_WAKE_MS     = 50;
  localparam int unsigned RECAL_EXTRA_MS  = 200;
  localparam int unsigned HIB_MIN_MS      = 10;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned HW_WAKE_CYC     = HW_WAKE_MS * CYC_PER_MS;
  localparam int unsigned INIT_CYC        = INIT_MS * CYC_PER_MS;
  localparam int unsigned HIB_WAKE_CYC    = HIB_WAKE_MS * CYC_PER_MS;
  localparam int unsigned RECAL_EXTRA_CYC = RECAL_EXTRA_MS * CYC_PER_MS;

  // ---------------------------------------------------------------------------
  // UART
  // ---------------------------------------------------------------------------
  localparam int unsigned UART_BOOT_BPS  = 115200;
  localparam int unsigned UART_MAX_BPS   = 3_000_000;
  localparam int unsigned UART_DATA_BITS = 8;
  localparam int unsigned UART_BOOT_DIV  = CLK_HZ / UART_BOOT_BPS;
  localparam int unsigned UART_MIN_DIV   = CLK_HZ / UART_MAX_BPS;
  localparam int unsigned DIV_W          = 16;
  localparam logic [DIV_W-1:0] BOOT_DIV  = DIV_W'(UART_BOOT_DIV);
  localparam logic [DIV_W-1:0] MIN_DIV   = DIV_W'(UART_MIN_DIV);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_OFF     = 3'b000,
    PWR_HW_WAKE = 3'b001,
    PWR_INIT    = 3'b011,
    PWR_READY   = 3'b010,
    PWR_HIB     = 3'b110,
    PWR_HIB_WK  = 3'b111
  } pwr_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_t;

endpackage

// ### hw/uart_char_tx.sv
// Serial character sender, eight data bits, LSB first, no parity, one stop.
`timescale 1ns/1ps
module uart_char_tx
  import link_power_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             cts_ok_i,
  input  wire byte_beat_t       tx_i,
  output logic                  tx_ready_o,
  output logic                  txd_o
);

  logic [DIV_W-1:0] bit_cnt_r;
  logic [9:0]       shift_r;
  logic [3:0]       bits_left_r;

  // Ready only when idle and the far side permits sending.
  assign tx_ready_o = (bits_left_r == 4'h0) && cts_ok_i; // RL18

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bit_cnt_r   <= '0;
      shift_r     <= 10'h3ff;
      bits_left_r <= 4'h0;
    end else if (bits_left_r == 4'h0) begin
      if (tx_i.valid && cts_ok_i) begin
        shift_r     <= {1'b1, tx_i.data, 1'b0}; // RL18
        bits_left_r <= 4'(UART_DATA_BITS + 2);
        bit_cnt_r   <= div_i - 1'b1;
      end
    end else if (bit_cnt_r == '0) begin
      shift_r     <= {1'b1, shift_r[9:1]}; // RL18
      bits_left_r <= bits_left_r - 4'h1;
      bit_cnt_r   <= div_i - 1'b1;
    end else begin
      bit_cnt_r <= bit_cnt_r - 1'b1;
    end
  end

  assign txd_o = (bits_left_r == 4'h0) ? 1'b1 : shift_r[0];

endmodule

// ### dv/host_uart_model.sv
// Host side model: serial receiver on the block's transmit line.
`timescale 1ns/1ps
module host_uart_model
  import link_power_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             rxd_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             hold_i,
  output logic                  cts_n_o,
  output int                    count_o
);
  logic [7:0] hist [0:15];
  logic [7:0] sh;
  int         errs;

  // The host stalls the sender by raising its clear-to-send line.
  assign cts_n_o = hold_i;

  initial begin
    count_o = 0;
    errs = 0;
    forever begin
      @(negedge rxd_i);
      repeat (div_i / 2) @(posedge clk_sys_i);
      if (rxd_i !== 1'b0) continue;
      for (int i = 0; i < 8; i++) begin
        repeat (div_i) @(posedge clk_sys_i);
        sh[i] = rxd_i;
      end
      repeat (div_i) @(posedge clk_sys_i);
      if (rxd_i !== 1'b1) errs++;
      hist[count_o[3:0]] = sh;
      count_o++;
    end
  end
endmodule

// ### dv/host_link_power_control_tb.sv
// Self-checking bench for the host link power control block.
`timescale 1ns/1ps
module host_link_power_control_tb;
  import link_power_pkg::*;
  logic             clk_sys_i, rst_i, restart_n, hib_n, temp_shift, sel_n;
  logic             cts_n, hold, rate_set, rx_busy, xfer_req;
  logic [DIV_W-1:0] rate_div, line_div;
  byte_beat_t       tx;
  logic             tx_ready, txd, rts_n, attn, ready, hib, xtal;
  logic [2:0]       pwr;
  int               rx_count, failures, samples_checked;

  host_link_power_control #(.HW_WAKE_CYCLES(20), .INIT_CYCLES(40),
    .HIB_WAKE_CYCLES(30), .RECAL_CYCLES(25)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .module_restart_pin_n_i(restart_n), .hibernate_request_pin_n_i(hib_n),
    .temp_shift_i(temp_shift), .host_link_select_n_i(sel_n),
    .cts_n_i(cts_n), .rate_set_i(rate_set), .rate_div_i(rate_div),
    .tx_i(tx), .tx_ready_o(tx_ready), .txd_o(txd), .rts_n_o(rts_n),
    .rx_busy_i(rx_busy), .xfer_request_i(xfer_req),
    .host_attention_line_o(attn), .ready_o(ready), .hibernate_o(hib),
    .slow_xtal_en_o(xtal), .pwr_state_o(pwr));

  host_uart_model host_u (.clk_sys_i(clk_sys_i), .rxd_i(txd),
    .div_i(line_div), .hold_i(hold), .cts_n_o(cts_n), .count_o(rx_count));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Counts cycles from the pin release until ready rises.
  task automatic wait_ready(int lo, int hi);
    int n = 0;
    #1;
    while (ready !== 1'b1 && n < hi) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check("ready_o", ready, 1'b1);
    check("ready_not_early", 16'(n >= lo), 16'h0001);
  endtask

  // Holds valid until an edge at which the sender is ready takes it.
  task automatic send_byte(logic [7:0] b);
    int n = 0;
    @(posedge clk_sys_i);
    tx <= '{valid: 1'b1, data: b};
    #1;
    while (tx_ready !== 1'b1 && n < 30000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    @(posedge clk_sys_i);
    tx <= '{valid: 1'b0, data: 8'h00};
  endtask

  task automatic expect_bytes(int k, int max);
    int n = 0;
    while (rx_count < k && n < max) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check("rx_count", 16'(rx_count), 16'(k));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    failures++;
    give_verdict();
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    restart_n = 1'b0;
    hib_n = 1'b1;
    {temp_shift, sel_n, hold, rate_set, rx_busy, xfer_req} = 6'b010000;
    rate_div = 16'h0000;
    line_div = BOOT_DIV;
    tx = '{valid: 1'b0, data: 8'h00};
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    tick(5);
    check("txd_idle", txd, 1'b1);
    check("pwr_off", pwr, PWR_OFF);
    @(posedge clk_sys_i);
    restart_n <= 1'b1;
    wait_ready(60, 80);
    check("pwr_ready", pwr, PWR_READY);
    @(posedge clk_sys_i);
    xfer_req <= 1'b1;
    tick(4);
    check("attention_up", attn, 1'b1);
    @(posedge clk_sys_i);
    sel_n <= 1'b0;
    tick(4);
    check("attention_masked", attn, 1'b0);
    @(posedge clk_sys_i);
    sel_n <= 1'b1;
    xfer_req <= 1'b0;
    tick(4);
    check("attention_down", attn, 1'b0);
    @(posedge clk_sys_i);
    rx_busy <= 1'b1;
    tick(4);
    check("rts_busy", rts_n, 1'b1);
    @(posedge clk_sys_i);
    rx_busy <= 1'b0;
    tick(4);
    check("rts_free", rts_n, 1'b0);
    @(posedge clk_sys_i);
    hold <= 1'b1;
    tick(5);
    check("cts_stall", tx_ready, 1'b0);
    @(posedge clk_sys_i);
    hold <= 1'b0;
    tick(5);
    check("cts_free", tx_ready, 1'b1);
    send_byte(8'ha5);
    expect_bytes(1, 25000);
    check("boot_rate_byte", host_u.hist[0], 8'ha5);
    @(posedge clk_sys_i);
    rate_div <= 16'h000a;
    rate_set <= 1'b1;
    line_div <= MIN_DIV;
    @(posedge clk_sys_i);
    rate_set <= 1'b0;
    send_byte(8'h81);
    send_byte(8'h7e);
    expect_bytes(3, 2000);
    check("fast_byte_a", host_u.hist[1], 8'h81);
    check("fast_byte_b", host_u.hist[2], 8'h7e);
    check("stop_errors", 16'(host_u.errs), 16'h0000);
    @(posedge clk_sys_i);
    hib_n <= 1'b0;
    tick(20);
    check("hibernate_o", hib, 1'b1);
    check("slow_xtal", xtal, 1'b1);
    check("hib_not_ready", ready, 1'b0);
    @(posedge clk_sys_i);
    hib_n <= 1'b1;
    wait_ready(30, 45);
    @(posedge clk_sys_i);
    temp_shift <= 1'b1;
    hib_n <= 1'b0;
    tick(20);
    @(posedge clk_sys_i);
    hib_n <= 1'b1;
    wait_ready(55, 75);
    @(posedge clk_sys_i);
    temp_shift <= 1'b0;
    restart_n <= 1'b0;
    tick(50);
    check("restart_not_ready", ready, 1'b0);
    @(posedge clk_sys_i);
    restart_n <= 1'b1;
    wait_ready(60, 80);
    tick(10);
    check("final_ready", ready, 1'b1);
    give_verdict();
  end
endmodule
